// >>> logic/lcp_consts.svh
// Offsets, field positions, reset values and fixed codes of the register slice
`ifndef LCP_CONSTS_SVH
`define LCP_CONSTS_SVH
// Register indices; byte address is four times the index
`define LCP_IDX_LINK_CTL2 8'h70
`define LCP_IDX_LINK_STS2 8'h72
`define LCP_IDX_SLOT_CAP2 8'h74
`define LCP_IDX_SLOT_CTL2 8'h78
`define LCP_IDX_SLOT_STS2 8'h7a
`define LCP_IDX_PM_CAP 8'hc0
// Link control second, upper part
`define LCP_POS_ENTER_CMP 4
`define LCP_POS_MOD_CMP 10
`define LCP_POS_SKIP 11
`define LCP_POS_CMP_DEEMPH 12
// Link status second
`define LCP_POS_CUR_DEEMPH 0
// Power management capability header
`define LCP_POS_CAP_ID 0
`define LCP_POS_NEXT_PTR 8
`define LCP_POS_PM_VER 16
`define LCP_POS_PME_CLK 19
`define LCP_CAP_ID 8'h01
`define LCP_NEXT_PTR_UP 8'h00
`define LCP_NEXT_PTR_DN 8'hd0
`define LCP_PM_VER 3'h3
`define LCP_PME_CLK 1'h0
// Reset values
`define LCP_RST_BIT 1'h0
`define LCP_RST_CMP_CTL 3'h0
// Bus answers
`define LCP_RESP_OKAY 2'h0
`define LCP_RESP_SLVERR 2'h2
`endif

// >>> logic/lcp_pkg.sv
// Types shared by the compliance and power management register slice
package lcp_pkg;
  typedef enum logic [2:0]
  {
    LCP_CMP_OFF = 3'b001,
    LCP_CMP_SW = 3'b010,
    LCP_CMP_OTHER = 3'b100
  } lcp_cmp_e;
  // State reported by the link training state machine
  typedef struct packed {
    logic in_compliance;
    logic rate_5g;
    logic line_deemph_35;
  } lcp_ltssm_s;
  // Controls handed to the transmit pattern generator
  typedef struct packed {
    logic send_modified;
    logic insert_skip;
    logic deemph_35;
  } lcp_tx_s;
  // One register write from the bus
  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [31:0] data;
    logic [3:0] strb;
  } lcp_wr_s;
endpackage

// >>> logic/lcp_cfg_field.sv
// One writable configuration field, sticky or cleared by hot reset
module lcp_cfg_field
  import lcp_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0,
  parameter bit STICKY = 1'b1
)
(
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hot_reset,
  // Write port
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // Stored value
  output logic [WIDTH-1:0] value
);
  if (WIDTH < 1 || WIDTH > 32)
  begin : g_bad_width
    $error("lcp_cfg_field: WIDTH must be 1 to 32");
  end

  // Sticky fields keep their value across a hot reset of the link
  always_ff @(posedge core_clk)
  begin
    if (rst || (hot_reset && !STICKY))
      value <= RESET_VAL;
    else if (wr_en)
      value <= wr_data;
  end
endmodule

// >>> logic/lcp_axil_slave.sv
// AXI4-Lite slave front end with one write and one read in flight
module lcp_axil_slave
  import lcp_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Write channels
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // Read channels
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Register side
  output lcp_wr_s wr,
  input wire logic wr_hit,
  output logic [7:0] rd_idx,
  input wire logic rd_hit,
  input wire logic [31:0] rd_data
);
  `include "lcp_consts.svh"
  if (ADDR_W < 11 || ADDR_W > 32)
  begin : g_bad_addr
    $error("lcp_axil_slave: ADDR_W must be 11 to 32");
  end

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic commit;
  logic aw_ok;
  logic ar_ok;

  assign commit = aw_held && w_held && !s_bvalid;
  assign aw_ok = (aw_addr[ADDR_W-1:10] == '0);
  assign ar_ok = (s_araddr[ADDR_W-1:10] == '0);
  assign wr = '{en: commit && aw_ok, idx: aw_addr[9:2], data: w_data,
                strb: w_strb};
  assign rd_idx = s_araddr[9:2];

  ////////////////////////////////////////////////////////////////////////////
  // Address and data are taken in either order, then written together
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      s_awready <= 1'b0;
      aw_addr <= '0;
    end
    else if (commit)
    begin
      aw_held <= 1'b0;
      s_awready <= 1'b1;
    end
    else if (s_awvalid && s_awready)
    begin
      aw_held <= 1'b1;
      s_awready <= 1'b0;
      aw_addr <= s_awaddr;
    end
    else
      s_awready <= !aw_held;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      w_held <= 1'b0;
      s_wready <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end
    else if (commit)
    begin
      w_held <= 1'b0;
      s_wready <= 1'b1;
    end
    else if (s_wvalid && s_wready)
    begin
      w_held <= 1'b1;
      s_wready <= 1'b0;
      w_data <= s_wdata;
      w_strb <= s_wstrb;
    end
    else
      s_wready <= !w_held;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_bvalid <= 1'b0;
      s_bresp <= `LCP_RESP_OKAY;
    end
    else if (commit)
    begin
      s_bvalid <= 1'b1;
      s_bresp <= (wr_hit && aw_ok) ? `LCP_RESP_OKAY : `LCP_RESP_SLVERR;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data are sampled at the address handshake
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= `LCP_RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= (rd_hit && ar_ok) ? rd_data : 32'h0;
      s_rresp <= (rd_hit && ar_ok) ? `LCP_RESP_OKAY : `LCP_RESP_SLVERR;
    end
    else if (s_rvalid && s_rready)
    begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
    else if (!s_rvalid)
      s_arready <= 1'b1;
  end
endmodule

// >>> logic/lcp_link_cmp_pm_regs.sv
// Compliance controls, link status and power management header of one port
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module lcp_link_cmp_pm_regs
  import lcp_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b0,
  parameter int ADDR_W = 12
)
(
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hot_reset,
  // Lock control for the next capability pointer
  input wire logic next_ptr_unlock,
  // Link training state machine
  input wire lcp_ltssm_s ltssm,
  output lcp_tx_s tx,
  output logic enter_compliance,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  `include "lcp_consts.svh"

  localparam logic [7:0] NEXT_PTR_RST =
    IS_UPSTREAM ? `LCP_NEXT_PTR_UP : `LCP_NEXT_PTR_DN;

  lcp_wr_s wr;
  logic wr_hit;
  logic [7:0] rd_idx;
  logic rd_hit;
  logic [31:0] rd_data;
  logic [2:0] cmp_ctl;
  logic modified_compliance_enable;
  logic compliance_skip_set_enable;
  logic compliance_deemphasis_select;
  logic [7:0] next_capability_pointer;
  logic current_deemphasis;
  lcp_cmp_e cmp_state;
  lcp_cmp_e next_cmp_state;
  logic wr_ctl2;
  logic wr_pm;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end
  lcp_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .core_clk(core_clk),
    .rst(rst),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr(wr),
    .wr_hit(wr_hit),
    .rd_idx(rd_idx),
    .rd_hit(rd_hit),
    .rd_data(rd_data)
  );

  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx == `LCP_IDX_LINK_CTL2) || (idx == `LCP_IDX_LINK_STS2) ||
                 (idx == `LCP_IDX_SLOT_CAP2) || (idx == `LCP_IDX_SLOT_CTL2) ||
                 (idx == `LCP_IDX_SLOT_STS2) || (idx == `LCP_IDX_PM_CAP);
  endfunction

  assign wr_hit = idx_mapped(wr.idx);
  assign rd_hit = idx_mapped(rd_idx);
  assign wr_ctl2 = wr.en && (wr.idx == `LCP_IDX_LINK_CTL2);
  assign wr_pm = wr.en && (wr.idx == `LCP_IDX_PM_CAP);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields; compliance controls survive a hot reset
  lcp_cfg_field #(
    .WIDTH(1),
    .RESET_VAL(`LCP_RST_BIT),
    .STICKY(1'b1)
  ) u_enter_cmp (
    .core_clk(core_clk),
    .rst(rst),
    .hot_reset(hot_reset),
    .wr_en(wr_ctl2 && wr.strb[0]),
    .wr_data(wr.data[`LCP_POS_ENTER_CMP]),
    .value(enter_compliance)
  );

  lcp_cfg_field #(
    .WIDTH(3),
    .RESET_VAL(`LCP_RST_CMP_CTL),
    .STICKY(1'b1)
  ) u_cmp_ctl (
    .core_clk(core_clk),
    .rst(rst),
    .hot_reset(hot_reset),
    .wr_en(wr_ctl2 && wr.strb[1]),
    .wr_data(wr.data[`LCP_POS_CMP_DEEMPH:`LCP_POS_MOD_CMP]),
    .value(cmp_ctl)
  );

  assign modified_compliance_enable = cmp_ctl[0];
  assign compliance_skip_set_enable = cmp_ctl[1];
  assign compliance_deemphasis_select = cmp_ctl[2];

  // Writable only while unlocked; a hot reset restores the default
  lcp_cfg_field #(
    .WIDTH(8),
    .RESET_VAL(NEXT_PTR_RST),
    .STICKY(1'b0)
  ) u_next_ptr (
    .core_clk(core_clk),
    .rst(rst),
    .hot_reset(hot_reset),
    .wr_en(wr_pm && wr.strb[1] && next_ptr_unlock),
    .wr_data(wr.data[`LCP_POS_NEXT_PTR+7:`LCP_POS_NEXT_PTR]),
    .value(next_capability_pointer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // How compliance was entered, latched at the entry
  always_comb
  begin
    next_cmp_state = cmp_state;
    case (cmp_state)
      LCP_CMP_OFF:
        if (ltssm.in_compliance)
          next_cmp_state = enter_compliance ? LCP_CMP_SW : LCP_CMP_OTHER;
      LCP_CMP_SW, LCP_CMP_OTHER:
        if (!ltssm.in_compliance)
          next_cmp_state = LCP_CMP_OFF;
      default:
        next_cmp_state = LCP_CMP_OFF;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      cmp_state <= LCP_CMP_OFF;
    else
      cmp_state <= next_cmp_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern controls
  // modified pattern select
  always_ff @(posedge core_clk)
  begin
    if (rst)
      tx.send_modified <= 1'b0;
    else
      tx.send_modified <= ltssm.in_compliance && modified_compliance_enable;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      tx.insert_skip <= 1'b0;
    else
      tx.insert_skip <= ltssm.in_compliance && compliance_skip_set_enable;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      tx.deemph_35 <= 1'b0;
    else if (cmp_state == LCP_CMP_SW)
      tx.deemph_35 <= compliance_deemphasis_select;
    else
      tx.deemph_35 <= ltssm.line_deemph_35;
  end

  // level in use at 5.0 Gbps
  // Held at 2.5 Gbps, where the value carries no meaning
  always_ff @(posedge core_clk)
  begin
    if (rst)
      current_deemphasis <= `LCP_RST_BIT;
    else if (ltssm.rate_5g)
      current_deemphasis <= tx.deemph_35;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb
  begin
    rd_data = 32'h0;
    case (rd_idx)
      `LCP_IDX_LINK_CTL2:
      begin
        rd_data[`LCP_POS_ENTER_CMP] = enter_compliance;
        rd_data[`LCP_POS_CMP_DEEMPH:`LCP_POS_MOD_CMP] = cmp_ctl;
      end
      `LCP_IDX_LINK_STS2:
        rd_data[`LCP_POS_CUR_DEEMPH] = current_deemphasis;
      `LCP_IDX_PM_CAP:
      begin
        rd_data[`LCP_POS_CAP_ID+7:`LCP_POS_CAP_ID] = `LCP_CAP_ID;
        rd_data[`LCP_POS_NEXT_PTR+7:`LCP_POS_NEXT_PTR] =
          next_capability_pointer;
        rd_data[`LCP_POS_PM_VER+2:`LCP_POS_PM_VER] = `LCP_PM_VER;
        rd_data[`LCP_POS_PME_CLK] = `LCP_PME_CLK;
      end
      default:
        rd_data = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic ar_take;
  logic [7:0] ar_idx_q;
  logic ar_ok_q;
  assign ar_take = s_arvalid && s_arready;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ar_idx_q <= 8'h00;
      ar_ok_q <= 1'b0;
    end
    else if (ar_take)
    begin
      ar_idx_q <= rd_idx;
      ar_ok_q <= (s_araddr[ADDR_W-1:10] == '0);
    end
  end

  AST_MOD_CMP: assert property (
    ltssm.in_compliance && modified_compliance_enable |=> tx.send_modified)
    else $error("modified pattern not sent in compliance");
  AST_SKIP: assert property (
    ltssm.in_compliance && compliance_skip_set_enable |=>
      tx.insert_skip && (tx.send_modified == $past(
        modified_compliance_enable)))
    else $error("skip sets not inserted in compliance");
  AST_CMP_DEEMPH: assert property (
    cmp_state == LCP_CMP_SW |=>
      tx.deemph_35 == $past(compliance_deemphasis_select))
    else $error("compliance de-emphasis not applied");
  AST_SW_ENTRY: assert property (
    cmp_state == LCP_CMP_OFF && ltssm.in_compliance && !enter_compliance
      ##1 ltssm.in_compliance |=>
      tx.deemph_35 == $past(ltssm.line_deemph_35))
    else $error("compliance de-emphasis used without software entry");
  AST_CUR_DEEMPH: assert property (
    ltssm.rate_5g ##1 ltssm.rate_5g |=>
      current_deemphasis == $past(tx.deemph_35) &&
      $past(current_deemphasis) == $past(tx.deemph_35, 2))
    else $error("current de-emphasis status wrong");
  AST_CAP_ID: assert property (
    ar_take && rd_idx == `LCP_IDX_PM_CAP |=>
      !ar_ok_q || s_rdata[7:0] == `LCP_CAP_ID && s_rvalid)
    else $error("capability ID not 0x1");
  AST_NEXT_UP: assert property (
    IS_UPSTREAM && ($past(hot_reset) || $past(rst)) |->
      next_capability_pointer == `LCP_NEXT_PTR_UP)
    else $error("upstream next pointer default wrong");
  AST_NEXT_DN: assert property (
    !IS_UPSTREAM && ($past(hot_reset) || $past(rst)) |->
      next_capability_pointer == `LCP_NEXT_PTR_DN)
    else $error("downstream next pointer default wrong");
  AST_PM_VER: assert property (
    ar_take && rd_idx == `LCP_IDX_PM_CAP |=>
      !ar_ok_q || s_rdata[18:16] == `LCP_PM_VER)
    else $error("power management version not 0x3");
  AST_PME_CLK: assert property (
    ar_take && rd_idx == `LCP_IDX_PM_CAP |=>
      !ar_ok_q || (s_rdata[19] == 1'b0 && s_rdata[31:20] == 12'h000))
    else $error("PME clock or reserved bits not zero");
  AST_RSVD_ZERO: assert property (
    ar_take && (rd_idx == `LCP_IDX_SLOT_CAP2 ||
      rd_idx == `LCP_IDX_SLOT_CTL2 || rd_idx == `LCP_IDX_SLOT_STS2 ||
      rd_idx == `LCP_IDX_LINK_STS2) |=>
      s_rdata[31:1] == 31'h0 && s_rvalid &&
      (s_rdata[0] == 1'b0 || ar_idx_q == `LCP_IDX_LINK_STS2))
    else $error("reserved bits not zero");

  COV_SW_CMP: cover property (
    cmp_state == LCP_CMP_SW && compliance_deemphasis_select);
  COV_MOD_SKIP: cover property (tx.send_modified && tx.insert_skip);
  COV_WRITE: cover property (s_bvalid && s_bready &&
    s_bresp == `LCP_RESP_OKAY);
  COV_PM_READ: cover property (ar_take && rd_idx == `LCP_IDX_PM_CAP);
endmodule

// >>> tb/test_lcp_link_cmp_pm_regs.sv
// Self-checking bench for the compliance and power management slice
`include "lcp_consts.svh"
module test_lcp_link_cmp_pm_regs
  import lcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hot_reset = 1'b0;
  logic next_ptr_unlock = 1'b0;
  lcp_ltssm_s ltssm = '0;
  lcp_tx_s tx;
  logic enter_compliance;
  logic [11:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] up_rdata;
  localparam logic [11:0] CTL_ADDR = {2'b00, `LCP_IDX_LINK_CTL2, 2'b00};
  localparam logic [11:0] PM_ADDR = {2'b00, `LCP_IDX_PM_CAP, 2'b00};
  logic [7:0] rsvd_idx [3] = '{`LCP_IDX_SLOT_CAP2, `LCP_IDX_SLOT_CTL2,
    `LCP_IDX_SLOT_STS2};
  logic [11:0] bad_addr [2] = '{12'h004, 12'hc00};
  // Compliance cases: control word, line de-emphasis, expected controls
  logic [31:0] case_ctl [6] = '{32'h0400, 32'h0800, 32'h1c10, 32'h0c10,
    32'h1c00, 32'h0000};
  logic case_line [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [2:0] case_tx [6] = '{3'h4, 3'h2, 3'h7, 3'h6, 3'h6, 3'h1};
  ////////////////////////////////////////////////////////////////////////////
  lcp_link_cmp_pm_regs #(.IS_UPSTREAM(1'b0), .ADDR_W(12))
  i_lcp_link_cmp_pm_regs
  (
    .core_clk(core_clk), .rst(rst), .hot_reset(hot_reset),
    .next_ptr_unlock(next_ptr_unlock), .ltssm(ltssm), .tx(tx),
    .enter_compliance(enter_compliance),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready)
  );
  // Upstream twin on the same bus; only its read data are looked at
  lcp_link_cmp_pm_regs #(.IS_UPSTREAM(1'b1), .ADDR_W(12))
  i_lcp_link_cmp_pm_regs_up
  (
    .core_clk(core_clk), .rst(rst), .hot_reset(hot_reset),
    .next_ptr_unlock(next_ptr_unlock), .ltssm(ltssm), .tx(),
    .enter_compliance(),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(),
    .s_bresp(), .s_bvalid(), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(),
    .s_rdata(up_rdata), .s_rresp(), .s_rvalid(), .s_rready(rready)
  );
  ////////////////////////////////////////////////////////////////////////////
  always #10 core_clk = ~core_clk;

  // A hang ends the run as a failure
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [31:0] pm_exp(input logic [7:0] nxt);
    return {12'h000, `LCP_PME_CLK, `LCP_PM_VER, nxt, `LCP_CAP_ID};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count = err_count + 1;
    end
  endtask

  // Address and data offered together; each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] exp_resp);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge core_clk);
      if (!aw_done && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do
      @(posedge core_clk);
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, exp_resp});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp_data,
    input logic [1:0] exp_resp);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge core_clk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge core_clk);
    rready <= 1'b0;
    check(rdata, exp_data);
    check({30'h0, rresp}, {30'h0, exp_resp});
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    // Reset values of the header and status
    rd(PM_ADDR, pm_exp(`LCP_NEXT_PTR_DN), `LCP_RESP_OKAY);
    check(up_rdata, pm_exp(`LCP_NEXT_PTR_UP));
    rd(addr_of(`LCP_IDX_LINK_CTL2), 32'h0, `LCP_RESP_OKAY);
    rd(addr_of(`LCP_IDX_LINK_STS2), 32'h0, `LCP_RESP_OKAY);
    // Reserved registers ignore writes
    foreach (rsvd_idx[i])
    begin
      wr(addr_of(rsvd_idx[i]), 32'hffffffff, 4'hf, `LCP_RESP_OKAY);
      rd(addr_of(rsvd_idx[i]), 32'h0, `LCP_RESP_OKAY);
    end
    wr(addr_of(`LCP_IDX_LINK_STS2), 32'hffffffff, 4'hf, `LCP_RESP_OKAY);
    rd(addr_of(`LCP_IDX_LINK_STS2), 32'h0, `LCP_RESP_OKAY);
    // Unmapped places answer with an error
    foreach (bad_addr[i])
    begin
      wr(bad_addr[i], 32'hffffffff, 4'hf, `LCP_RESP_SLVERR);
      rd(bad_addr[i], 32'h0, `LCP_RESP_SLVERR);
    end
    // Byte lanes gate the control bits; reserved bits stay zero
    wr(CTL_ADDR, 32'hffffffff, 4'h2, `LCP_RESP_OKAY);
    rd(addr_of(`LCP_IDX_LINK_CTL2), 32'h1c00, `LCP_RESP_OKAY);
    wr(CTL_ADDR, 32'hffffffff, 4'h1, `LCP_RESP_OKAY);
    rd(addr_of(`LCP_IDX_LINK_CTL2), 32'h1c10, `LCP_RESP_OKAY);
    check({31'h0, enter_compliance}, 32'h1);
    // Constant fields ignore writes; pointer locked
    wr(addr_of(`LCP_IDX_PM_CAP), 32'hffffffff, 4'hf, `LCP_RESP_OKAY);
    rd(PM_ADDR, pm_exp(`LCP_NEXT_PTR_DN), `LCP_RESP_OKAY);
    next_ptr_unlock <= 1'b1;
    wr(addr_of(`LCP_IDX_PM_CAP), 32'hffffab00, 4'hf, `LCP_RESP_OKAY);
    rd(addr_of(`LCP_IDX_PM_CAP), pm_exp(8'hab), `LCP_RESP_OKAY);
    next_ptr_unlock <= 1'b0;
    // Hot reset restores the pointer but keeps sticky controls
    @(posedge core_clk);
    hot_reset <= 1'b1;
    @(posedge core_clk);
    hot_reset <= 1'b0;
    rd(PM_ADDR, pm_exp(`LCP_NEXT_PTR_DN), `LCP_RESP_OKAY);
    check(up_rdata, pm_exp(`LCP_NEXT_PTR_UP));
    rd(addr_of(`LCP_IDX_LINK_CTL2), 32'h1c10, `LCP_RESP_OKAY);
    // status read only at 5.0 Gbps
    foreach (case_ctl[i])
    begin
      wr(CTL_ADDR, case_ctl[i], 4'h3, `LCP_RESP_OKAY);
      @(posedge core_clk);
      ltssm <= '{in_compliance: 1'b1, rate_5g: 1'b1,
        line_deemph_35: case_line[i]};
      repeat (4) @(posedge core_clk);
      check({29'h0, tx}, {29'h0, case_tx[i]});
      rd(addr_of(`LCP_IDX_LINK_STS2), {31'h0, case_tx[i][0]},
        `LCP_RESP_OKAY);
      // Leaving compliance drops the pattern controls
      ltssm <= '{in_compliance: 1'b0, rate_5g: 1'b1, line_deemph_35: 1'b0};
      repeat (3) @(posedge core_clk);
      check({29'h0, tx}, 32'h0);
    end
    // Controls back at their default outside test use
    wr(addr_of(`LCP_IDX_LINK_CTL2), 32'h0, 4'h3, `LCP_RESP_OKAY);
    rd(addr_of(`LCP_IDX_LINK_CTL2), 32'h0, `LCP_RESP_OKAY);
    report_and_stop();
  end
endmodule
